// *** hw/rlct_pkg.sv ***
// Constants shared by both ends of the read latency code link:
// the latency parameter block image, opcodes and lookup helpers.
// Assumes both ends run on one clock that stands for the serial clock.
// Notes on behaviour
// - Parameter block starts with identifier 90h.
// - Length byte 56h locates the next parameter.
// - Header row holds ASCII F then C.
// - Basic read is 03h or 13h.
// - Fast read is 0Bh or 0Ch.
// - Dual-output read is 3Bh or 3Ch.
// - Quad-output read is 6Bh or 6Ch.
// - Dual I/O read is BBh or BCh.
// - Quad I/O read is EBh or ECh.
// - Row up to 50 MHz uses code 11b.
// - Code 11b: simple reads need no latency.
// - Code 11b: dual I/O has four dummies.
// - Code 11b: quad I/O two mode, one dummy.
// - Row up to 80 MHz uses code 00b.
// - Basic read unsupported at 80 MHz row.
// - Code 00b: fast, dual-out take eight dummies.
package rlct_pkg;
	localparam int TBL_BYTES = 88;
	localparam int OFF_ID = 0;
	localparam int OFF_LEN = 1;
	localparam int OFF_ROWS = 2;
	localparam int OFF_ROWLEN = 3;
	localparam int OFF_HDR = 4;
	localparam int OFF_OPC = 6;
	localparam int OFF_ROW1 = 18;
	localparam int NUM_OPC = 12;
	localparam int DATA_ROWS = 5;
	localparam logic [7:0] UNSUP = 8'hFF;
	localparam logic [7:0] QRY_OPC = 8'h5A;
	localparam logic [2:0] KIND_QRY = 3'h6;
	localparam logic [2:0] KIND_NONE = 3'h7;
	localparam logic [7:0] MAX_SCK_MHZ = 8'h85;
	localparam logic [7:0] TBL [0:TBL_BYTES-1] = '{
		8'h90, 8'h56, 8'h06, 8'h0E, 8'h46, 8'h43,
		8'h03, 8'h13, 8'h0B, 8'h0C, 8'h3B, 8'h3C, 8'h6B, 8'h6C,
		8'hBB, 8'hBC, 8'hEB, 8'hEC,
		8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'h01,
		8'h50, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'h00, 8'h08,
		8'h00, 8'h08, 8'h00, 8'h04, 8'h02, 8'h04,
		8'h5A, 8'h01, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'h00, 8'h08,
		8'h00, 8'h08, 8'h00, 8'h05, 8'h02, 8'h04,
		8'h68, 8'h02, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'h00, 8'h08,
		8'h00, 8'h08, 8'h00, 8'h06, 8'h02, 8'h05,
		8'h85, 8'h02, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

	typedef struct packed {
		logic unsup;
		logic [7:0] mode;
		logic [7:0] dummy;
	} rlct_lat_t;

	typedef struct packed {
		logic [2:0] kind;
		logic four;
	} rlct_op_t;

	// Table byte, FFh beyond the image
	function automatic logic [7:0] tbl_byte(input logic [31:0] idx);
		tbl_byte = UNSUP;
		if (idx < 32'(TBL_BYTES)) begin
			tbl_byte = TBL[idx];
		end
	endfunction

	// Opcode to read kind; the query opcode is served with no latency
	function automatic rlct_op_t op_decode(input logic [7:0] opc);
		op_decode = '{kind: KIND_NONE, four: 1'b0};
		if (opc == QRY_OPC) begin
			op_decode = '{kind: KIND_QRY, four: 1'b1};
		end
		for (int k = 0; k < NUM_OPC; k++) begin
			if (TBL[OFF_OPC + k] == opc) begin
				op_decode = '{kind: 3'(k / 2), four: 1'(k % 2)};
			end
		end
	endfunction

	// Mode and dummy cycles for a read kind under a latency code
	function automatic rlct_lat_t lat_lookup(input logic [1:0] code, input logic [2:0] kind);
		logic found;
		int base;
		lat_lookup = '{unsup: 1'b1, mode: UNSUP, dummy: UNSUP};
		found = 1'b0;
		base = 0;
		if (kind == KIND_QRY) begin
			lat_lookup = '{unsup: 1'b0, mode: 8'h00, dummy: 8'h00};
		end else if (kind != KIND_NONE) begin
			for (int r = 0; r < DATA_ROWS; r++) begin
				base = OFF_ROW1 + r * int'(TBL[OFF_ROWLEN]);
				if (!found && TBL[base + 1][1:0] == code) begin
					found = 1'b1;
					lat_lookup.mode = TBL[base + 2 + 2 * int'(kind)];
					lat_lookup.dummy = TBL[base + 3 + 2 * int'(kind)];
					lat_lookup.unsup = (lat_lookup.mode == UNSUP) || (lat_lookup.dummy == UNSUP);
				end
			end
		end
	endfunction

	// Latency code of the first row whose limit covers the clock rate
	function automatic logic [1:0] code_for_mhz(input int mhz);
		logic found;
		int base;
		code_for_mhz = 2'h2;
		found = 1'b0;
		base = 0;
		for (int r = 0; r < DATA_ROWS; r++) begin
			base = OFF_ROW1 + r * int'(TBL[OFF_ROWLEN]);
			if (!found && int'(TBL[base]) >= mhz) begin
				found = 1'b1;
				code_for_mhz = TBL[base + 1][1:0];
			end
		end
	endfunction
endpackage

// *** hw/rlct_if.sv ***
// Link between the read controller and the flash read port.
// Assumes both ends share one clock; all signals except lat_code are registered by their driver.
`timescale 1ns/1ps
`default_nettype none
interface rlct_if;
	logic cs_n;
	logic cmd_vld;
	logic [7:0] cmd;
	logic [31:0] addr;
	logic [1:0] lat_code;
	logic mode_drv;
	logic [7:0] dq;
	logic dq_oe;
	logic unsup;

	modport host (output cs_n, output cmd_vld, output cmd, output addr, output lat_code,
		output mode_drv, input dq, input dq_oe, input unsup);
	modport dev (input cs_n, input cmd_vld, input cmd, input addr, input lat_code,
		input mode_drv, output dq, output dq_oe, output unsup);
endinterface
`default_nettype wire

// *** hw/rlct_dev.sv ***
// Flash end: decodes read opcodes, waits the latency of the selected code,
// then streams bytes. Query reads stream the latency parameter block.
// Assumes the host ends every frame by raising cs_n for at least one cycle.
`timescale 1ns/1ps
`default_nettype none
module rlct_dev (
	input wire logic mclk_i,
	input wire logic resetn_i,
	rlct_if.dev lnk,
	output logic busy_o
);
	typedef enum logic [1:0] {
		RLCT_D_IDLE = 2'b00,
		RLCT_D_LAT = 2'b01,
		RLCT_D_DATA = 2'b11,
		RLCT_D_REFUSE = 2'b10
	} rlct_dst_t;

	typedef struct packed {
		rlct_dst_t st;
		logic [8:0] cnt;
		logic [31:0] ptr;
		logic qry;
		logic [7:0] dq;
		logic dq_oe;
		logic unsup;
		logic busy;
	} rlct_dreg_t;

	localparam rlct_dreg_t RST = '{st: RLCT_D_IDLE, cnt: 9'h000, ptr: 32'h0000_0000, qry: 1'b0,
		dq: 8'h00, dq_oe: 1'b0, unsup: 1'b0, busy: 1'b0};

	rlct_dreg_t r, nxt;

	function automatic logic [7:0] out_byte(input logic qry, input logic [31:0] ptr);
		out_byte = qry ? rlct_pkg::tbl_byte(ptr) : ptr[7:0];
	endfunction

	always_comb begin
		rlct_pkg::rlct_op_t op;
		rlct_pkg::rlct_lat_t lat;
		logic [8:0] total;
		nxt = r;
		op = rlct_pkg::op_decode(lnk.cmd);
		lat = rlct_pkg::lat_lookup(lnk.lat_code, op.kind);
		total = {1'b0, lat.mode} + {1'b0, lat.dummy};
		if (lnk.cs_n) begin
			nxt = RST;
		end else begin
			unique case (r.st)
				RLCT_D_IDLE: begin
					if (lnk.cmd_vld) begin
						nxt.busy = 1'b1;
						nxt.qry = (op.kind == rlct_pkg::KIND_QRY);
						nxt.ptr = op.four ? lnk.addr : {8'h00, lnk.addr[23:0]};
						nxt.cnt = total;
						if (lat.unsup) begin
							nxt.st = RLCT_D_REFUSE;
							nxt.unsup = 1'b1;
						end else if (total == 9'h000) begin
							nxt.st = RLCT_D_DATA;
							nxt.dq_oe = 1'b1;
							nxt.dq = out_byte(nxt.qry, nxt.ptr);
						end else begin
							nxt.st = RLCT_D_LAT;
						end
					end
				end
				RLCT_D_LAT: begin
					nxt.cnt = r.cnt - 9'h001;
					if (r.cnt == 9'h001) begin
						nxt.st = RLCT_D_DATA;
						nxt.dq_oe = 1'b1;
						nxt.dq = out_byte(r.qry, r.ptr);
					end
				end
				RLCT_D_DATA: begin
					nxt.ptr = r.ptr + 32'h0000_0001;
					nxt.dq = out_byte(r.qry, nxt.ptr);
				end
				RLCT_D_REFUSE: begin
					nxt.unsup = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			r <= RST;
		end else begin
			r <= nxt;
		end
	end

	assign lnk.dq = r.dq;
	assign lnk.dq_oe = r.dq_oe;
	assign lnk.unsup = r.unsup;
	assign busy_o = r.busy;
endmodule // rlct_dev
`default_nettype wire

// *** hw/rlct_host.sv ***
// Controller end: picks the latency code from its clock rate, refuses
// reads the table marks unsupported, issues the command, spends the
// tabulated mode and dummy cycles and gathers the requested bytes.
// Assumes the user holds request fields stable while start_i is high.
`timescale 1ns/1ps
`default_nettype none
module rlct_host #(
	parameter int SCK_MHZ = 50
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic start_i,
	input wire logic [7:0] opcode_i,
	input wire logic [31:0] addr_i,
	input wire logic [7:0] len_i,
	rlct_if.host lnk,
	output logic busy_o,
	output logic [7:0] data_o,
	output logic data_vld_o,
	output logic err_o,
	output logic [31:0] next_param_o,
	output logic [1:0] code_o
);
	if (SCK_MHZ < 1 || SCK_MHZ > int'(rlct_pkg::MAX_SCK_MHZ)) begin : g_bad_rate
		$error("SCK_MHZ outside the tabulated rows");
	end

	// The lookups walk the image by fixed offsets; a mismatch would read wrong bytes
	localparam int ROWS_END = rlct_pkg::OFF_ROW1 + rlct_pkg::DATA_ROWS * int'(rlct_pkg::TBL[rlct_pkg::OFF_ROWLEN]);
	localparam int OPC_END = rlct_pkg::OFF_OPC + rlct_pkg::NUM_OPC;
	localparam int ROWS_TOTAL = int'(rlct_pkg::TBL[rlct_pkg::OFF_ROWS]);
	if (OPC_END != rlct_pkg::OFF_ROW1 || ROWS_END != rlct_pkg::TBL_BYTES ||
		ROWS_TOTAL != rlct_pkg::DATA_ROWS + 1) begin : g_bad_tbl
		$error("latency table layout does not match its rows");
	end

	localparam logic [1:0] CODE = rlct_pkg::code_for_mhz(SCK_MHZ);

	// Gray order along IDLE, LAT, DATA, END
	typedef enum logic [2:0] {
		RLCT_H_IDLE = 3'b000,
		RLCT_H_LAT = 3'b001,
		RLCT_H_DATA = 3'b011,
		RLCT_H_END = 3'b010
	} rlct_hst_t;

	// All host state lives in one register image
	typedef struct packed {
		rlct_hst_t st;
		logic cs_n;
		logic cmd_vld;
		logic [7:0] cmd;
		logic [31:0] addr;
		logic mode_drv;
		logic [7:0] mcnt;
		logic [8:0] cnt;
		logic [7:0] left;
		logic [7:0] idx;
		logic qry;
		logic busy;
		logic [7:0] data;
		logic data_vld;
		logic err;
		logic [31:0] next_param;
	} rlct_hreg_t;

	localparam rlct_hreg_t RST = '{
		st: RLCT_H_IDLE,
		cs_n: 1'b1,
		cmd_vld: 1'b0,
		cmd: 8'h00,
		addr: 32'h0000_0000,
		mode_drv: 1'b0,
		mcnt: 8'h00,
		cnt: 9'h000,
		left: 8'h00,
		idx: 8'h00,
		qry: 1'b0,
		busy: 1'b0,
		data: 8'h00,
		data_vld: 1'b0,
		err: 1'b0,
		next_param: 32'h0000_0000
	};

	// Mode plus dummy cycles, widened so FFh entries cannot wrap
	function automatic logic [8:0] lat_total(input rlct_pkg::rlct_lat_t lat);
		lat_total = {1'b0, lat.mode} + {1'b0, lat.dummy};
	endfunction

	rlct_hreg_t r, nxt;

	always_comb begin
		rlct_pkg::rlct_op_t op;
		rlct_pkg::rlct_lat_t lat;
		nxt = r;
		nxt.cmd_vld = 1'b0;
		nxt.data_vld = 1'b0;
		nxt.err = 1'b0;
		op = rlct_pkg::op_decode(opcode_i);
		lat = rlct_pkg::lat_lookup(CODE, op.kind);
		unique case (r.st)
			RLCT_H_IDLE: begin
				if (start_i) begin
					// Refused requests pulse err and open no frame
					// never issue unsupported
					if (lat.unsup || len_i == 8'h00) begin
						nxt.err = 1'b1;
					end else begin
						nxt.st = RLCT_H_LAT;
						nxt.busy = 1'b1;
						nxt.cs_n = 1'b0;
						nxt.cmd_vld = 1'b1;
						nxt.cmd = opcode_i;
						nxt.addr = addr_i;
						// Query frames also yield where the next parameter block starts
						nxt.qry = (op.kind == rlct_pkg::KIND_QRY);
						nxt.mcnt = lat.mode;
						nxt.cnt = lat_total(lat);
						nxt.left = len_i;
						nxt.idx = 8'h00;
					end
				end
			end
			RLCT_H_LAT: begin
				nxt.mode_drv = (r.mcnt != 8'h00);
				if (r.mcnt != 8'h00) begin
					nxt.mcnt = r.mcnt - 8'h01;
				end
				if (r.cnt != 9'h000) begin
					nxt.cnt = r.cnt - 9'h001;
				end else begin
					nxt.mode_drv = 1'b0;
					nxt.st = RLCT_H_DATA;
				end
				// Early data or a refusal means the two ends disagree
				if (lnk.dq_oe || lnk.unsup) begin
					nxt.err = 1'b1;
					nxt.mode_drv = 1'b0;
					nxt.st = RLCT_H_END;
					nxt.cs_n = 1'b1;
				end
			end
			RLCT_H_DATA: begin
				if (lnk.unsup) begin
					nxt.err = 1'b1;
					nxt.st = RLCT_H_END;
					nxt.cs_n = 1'b1;
				end else if (lnk.dq_oe) begin
					nxt.data = lnk.dq;
					nxt.data_vld = 1'b1;
					nxt.idx = r.idx + 8'h01;
					nxt.left = r.left - 8'h01;
					if (r.qry && r.idx == 8'(rlct_pkg::OFF_LEN)) begin
						nxt.next_param = r.addr + {24'h00_0000, lnk.dq} + 32'h0000_0002;
					end
					if (r.left == 8'h01) begin
						nxt.st = RLCT_H_END;
						nxt.cs_n = 1'b1;
					end
				end else begin
					// A gap in the data stream means the two ends lost step
					nxt.err = 1'b1;
					nxt.st = RLCT_H_END;
					nxt.cs_n = 1'b1;
				end
			end
			RLCT_H_END: begin
				// One cycle with cs_n high keeps frames apart
				nxt.st = RLCT_H_IDLE;
				nxt.busy = 1'b0;
			end
			default: begin
				// Illegal state codes fall back to reset
				nxt = RST;
			end
		endcase
	end

	// Synchronous reset; every output except code_o and lat_code comes straight from this register
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			r <= RST;
		end else begin
			r <= nxt;
		end
	end

	// The latency code is a constant of the clock rate, not a register
	assign lnk.cs_n = r.cs_n;
	assign lnk.cmd_vld = r.cmd_vld;
	assign lnk.cmd = r.cmd;
	assign lnk.addr = r.addr;
	assign lnk.lat_code = CODE;
	assign lnk.mode_drv = r.mode_drv;
	assign busy_o = r.busy;
	assign data_o = r.data;
	assign data_vld_o = r.data_vld;
	assign err_o = r.err;
	assign next_param_o = r.next_param;
	assign code_o = CODE;
endmodule // rlct_host
`default_nettype wire

// *** verification/rlct_exp_pkg.sv ***
// Expected mode plus dummy cycles per read opcode, worked out independently.
// Assumes only latency codes 11b and 00b are exercised.
`default_nettype none
package rlct_exp_pkg;
	// Returns -1 where the command must be refused
	function automatic int exp_lat(input logic [1:0] code, input logic [7:0] opc);
		case (opc)
			8'h03, 8'h13: return (code == 2'h3) ? 0 : -1;
			8'h0B, 8'h0C, 8'h3B, 8'h3C, 8'h6B, 8'h6C: return (code == 2'h3) ? 0 : 8;
			8'hBB, 8'hBC: return 4;
			8'hEB, 8'hEC: return (code == 2'h3) ? 3 : 6;
			8'h5A: return 0;
			default: return -1;
		endcase
	endfunction
endpackage
`default_nettype wire

// *** verification/rlct_checker.sv ***
// Link checker for the read latency code interface.
// Assumes it watches the pair whose host runs at 50 MHz.
`timescale 1ns/1ps
`default_nettype none
module rlct_checker #(
	parameter logic [1:0] EXP_CODE = 2'h3
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic cs_n,
	input wire logic cmd_vld,
	input wire logic [7:0] cmd,
	input wire logic [31:0] addr,
	input wire logic [1:0] lat_code,
	input wire logic mode_drv,
	input wire logic [7:0] dq,
	input wire logic dq_oe,
	input wire logic unsup
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	logic [3:0] cnt_r;
	logic [3:0] lat_r;
	logic quad;
	assign quad = (cmd == 8'hEB) || (cmd == 8'hEC);
	// Cycles since the command, saturating so a long frame cannot wrap
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			cnt_r <= 4'h0;
			lat_r <= 4'h0;
		end else if (cmd_vld && !cs_n) begin
			cnt_r <= 4'h1;
			lat_r <= 4'(rlct_exp_pkg::exp_lat(lat_code, cmd));
		end else if (cnt_r != 4'hF) begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
	chk_code_fixed: assert property (lat_code == EXP_CODE)
		else $error("latency code differs");
	chk_oe_timing: assert property ($rose(dq_oe) |-> cnt_r == lat_r + 4'h1)
		else $error("data starts at wrong cycle");
	chk_known_cmd: assert property (cmd_vld |-> !cs_n && rlct_exp_pkg::exp_lat(lat_code, cmd) >= 0)
		else $error("command not allowed");
	chk_cmd_pulse: assert property (cmd_vld |=> !cmd_vld)
		else $error("command strobe too long");
	chk_mode_quad: assert property (cmd_vld && quad |=> mode_drv [*2] ##1 !mode_drv)
		else $error("quad mode cycles wrong");
	chk_mode_none: assert property (cmd_vld && !quad |=> !mode_drv)
		else $error("unexpected mode cycle");
	chk_first_byte: assert property ($rose(dq_oe) && cmd != 8'h5A |-> dq == addr[7:0])
		else $error("first byte wrong");
	chk_byte_incr: assert property (dq_oe && $past(dq_oe) && cmd != 8'h5A |-> dq == $past(dq) + 8'h01)
		else $error("data does not advance");
	chk_query_head: assert property ($rose(dq_oe) && cmd == 8'h5A && addr == 32'h0000_0000 |->
		dq == 8'h90 ##1 dq == 8'h56 ##1 dq == 8'h06 ##1 dq == 8'h0E ##1 dq == 8'h46 ##1 dq == 8'h43)
		else $error("block header wrong");
	chk_no_unsup: assert property (!unsup)
		else $error("unsupported flagged");
	chk_oe_release: assert property (cs_n && $past(cs_n) |-> !dq_oe)
		else $error("data driven outside frame");
	cover property (cmd_vld && quad);
	cover property ($rose(dq_oe) && cmd == 8'h5A);
	cover property (cmd_vld && cmd == 8'hBB);
endmodule // rlct_checker
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench: two host and device pairs, at 50 MHz and 80 MHz rates.
// Assumes one shared clock standing for the serial clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [7:0] OPS [0:11] = '{8'h03, 8'h13, 8'h0B, 8'h0C, 8'h3B, 8'h3C,
		8'h6B, 8'h6C, 8'hBB, 8'hBC, 8'hEB, 8'hEC};
	localparam logic [7:0] QT [0:39] = '{8'h90, 8'h56, 8'h06, 8'h0E, 8'h46, 8'h43,
		8'h03, 8'h13, 8'h0B, 8'h0C, 8'h3B, 8'h3C, 8'h6B, 8'h6C, 8'hBB, 8'hBC, 8'hEB, 8'hEC,
		8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'h01,
		8'h50, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'h00, 8'h08};
	logic mclk_i;
	logic resetn_i;
	logic [1:0] start;
	logic [7:0] opc [2];
	logic [31:0] adr [2];
	logic [7:0] len [2];
	wire logic [1:0] busy;
	wire logic [1:0] vld;
	wire logic [1:0] err;
	wire logic [1:0] dbusy;
	wire logic [7:0] dat [2];
	wire logic [31:0] nxt [2];
	wire logic [1:0] code [2];
	int fail_count;
	int checks;
	initial mclk_i = 1'h0;
	always #10 mclk_i = ~mclk_i;
	for (genvar g = 0; g < 2; g++) begin : pr
		rlct_if lnk();
		rlct_host #(.SCK_MHZ(g == 0 ? 50 : 80)) rlct_host_inst(.mclk_i(mclk_i), .resetn_i(resetn_i),
			.start_i(start[g]), .opcode_i(opc[g]), .addr_i(adr[g]), .len_i(len[g]), .lnk(lnk),
			.busy_o(busy[g]), .data_o(dat[g]), .data_vld_o(vld[g]), .err_o(err[g]),
			.next_param_o(nxt[g]), .code_o(code[g]));
		rlct_dev rlct_dev_inst(.mclk_i(mclk_i), .resetn_i(resetn_i), .lnk(lnk), .busy_o(dbusy[g]));
	end
	rlct_checker #(.EXP_CODE(2'h3)) rlct_checker_inst(.mclk_i(mclk_i), .resetn_i(resetn_i),
		.cs_n(pr[0].lnk.cs_n), .cmd_vld(pr[0].lnk.cmd_vld), .cmd(pr[0].lnk.cmd), .addr(pr[0].lnk.addr),
		.lat_code(pr[0].lnk.lat_code), .mode_drv(pr[0].lnk.mode_drv), .dq(pr[0].lnk.dq),
		.dq_oe(pr[0].lnk.dq_oe), .unsup(pr[0].lnk.unsup));
	task automatic conclude;
		if (fail_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One request from a falling edge; returns at a falling edge with the host idle
	task automatic xfer(input int p, input logic [7:0] o, input logic [31:0] a, input logic [7:0] l);
		int t;
		int n;
		int k;
		logic [7:0] e;
		t = (l == 8'h00) ? -1 : rlct_exp_pkg::exp_lat(p == 0 ? 2'h3 : 2'h0, o);
		start[p] = 1'h1;
		opc[p] = o;
		adr[p] = a;
		len[p] = l;
		@(posedge mclk_i);
		@(negedge mclk_i);
		start[p] = 1'h0;
		if (t < 0) begin
			cmp_bit(err[p], 1'h1);
			cmp_bit(busy[p], 1'h0);
			cmp_bit(dbusy[p], 1'h0);
			@(negedge mclk_i);
			return;
		end
		n = 1;
		k = 0;
		while (k < int'(l) && n < 600) begin
			if (vld[p] === 1'h1) begin
				if (k == 0) begin
					cmp_val(32'(n), 32'(t + 3));
					cmp_bit(busy[p], 1'h1);
					cmp_bit(dbusy[p], 1'h1);
				end
				e = (o == 8'h5A) ? QT[a + k] : 8'(a[7:0] + k);
				cmp_val(32'(dat[p]), 32'(e));
				k++;
			end
			@(negedge mclk_i);
			n++;
		end
		cmp_val(32'(k), 32'(l));
		while (busy[p] === 1'h1 && n < 900) begin
			@(negedge mclk_i);
			n++;
		end
		cmp_bit(busy[p], 1'h0);
		cmp_bit(dbusy[p], 1'h0);
		if (o == 8'h5A)
			cmp_val(nxt[p], a + 32'h0000_0058);
	endtask
	initial begin
		#400000;
		fail_count++;
		conclude;
	end
	initial begin
		resetn_i = 1'h0;
		start = 2'h0;
		opc = '{8'h00, 8'h00};
		adr = '{32'h0000_0000, 32'h0000_0000};
		len = '{8'h00, 8'h00};
		fail_count = 0;
		checks = 0;
		void'($urandom(32'h1480ab36));
		repeat (5) @(posedge mclk_i);
		@(negedge mclk_i);
		resetn_i = 1'h1;
		cmp_val(32'(code[0]), 32'h0000_0003);
		cmp_val(32'(code[1]), 32'h0000_0000);
		cmp_val(32'(pr[1].lnk.lat_code), 32'h0000_0000);
		for (int p = 0; p < 2; p++) begin
			xfer(p, 8'h5A, 32'h0000_0000, 8'h28);
			for (int i = 0; i < 12; i++)
				xfer(p, OPS[i], $urandom, 8'($urandom_range(8, 1)));
		end
		xfer(0, 8'h0B, 32'h0000_0010, 8'h00);
		xfer(0, 8'h77, 32'h0000_0010, 8'h01);
		xfer(0, 8'hBB, 32'h00FF_FFFE, 8'h04);
		xfer(1, 8'hEC, 32'hFFFF_FFF0, 8'hFF);
		repeat (24)
			xfer($urandom_range(1), OPS[$urandom_range(11)], $urandom, 8'($urandom_range(16, 1)));
		conclude;
	end
endmodule // tb
`default_nettype wire
